// ===== blit_command_field_decode.sv
// Strobed register access is this design's own decision.
`include "blit_defines.svh"
module blit_command_field_decode
  import blit_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic [11:0]   reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  input  wire pix_in_type    pix_in,
  output pix_out_type        pix_out,
  input  wire line_init_type line_init,
  input  wire logic          line_done,
  output logic      [23:0]   src_line_addr,
  output logic      [23:0]   dst_line_addr,
  output logic      [11:0]   y_count,
  output logic      [7:0]    raster_code,
  output logic               src_from_system,
  output logic               packed_layout,
  output logic               cmd_is_blt,
  output logic               cmd_is_line,
  output logic               cmd_start
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] drawing_command_reg;   // command word
  logic [31:0] foreground_color_reg;  // foreground / solid color
  logic [31:0] background_color_reg;  // background expansion color
  logic [31:0] stride_layout_reg;     // source and destination strides
  logic [31:0] color_compare_reg;     // transparency compare value
  logic [31:0] reg_rdata_reg;         // read data, one cycle late
  logic [31:0] rdata_next;            // read mux result
  pix_out_type pix_out_reg;           // pixel decision
  pix_out_type pix_out_next;
  logic [23:0] src_line_addr_reg;     // source line address
  logic [23:0] dst_line_addr_reg;     // destination line address
  logic [11:0] y_count_reg;           // line coordinate counter
  logic        cmd_start_reg;         // pulse on command write with a non-NOP type

  // decoded command fields
  logic        y_negative;
  logic        mono_source;
  logic        mono_pattern;
  logic        color_transp;
  logic        color_transp_pol;
  logic        mono_transp;
  logic        mono_transp_pol;
  logic        solid_source;
  logic        src_stride_own;
  logic        raster_code_two;
  logic [2:0]  cmd_type;
  logic [11:0] dst_stride;
  logic [11:0] src_stride;
  logic [7:0]  raster_code_next;
  logic        color_skip;
  logic        mono_skip;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  assign y_negative       = drawing_command_reg[`BIT_Y_NEGATIVE];
  assign mono_source      = drawing_command_reg[`BIT_MONO_SOURCE];
  assign mono_pattern     = drawing_command_reg[`BIT_MONO_PATTERN];
  assign color_transp     = drawing_command_reg[`BIT_COLOR_TRANSP];
  assign color_transp_pol = drawing_command_reg[`BIT_COLOR_TRANSP_POL];
  assign mono_transp      = drawing_command_reg[`BIT_MONO_TRANSP];
  assign mono_transp_pol  = drawing_command_reg[`BIT_MONO_TRANSP_POL];
  assign solid_source     = drawing_command_reg[`BIT_SOLID_SOURCE];
  assign src_stride_own   = drawing_command_reg[`BIT_SRC_STRIDE_OWN];
  assign raster_code_two  = drawing_command_reg[`BIT_RASTER_CODE_TWO];
  assign cmd_type         = drawing_command_reg[`CMD_TYPE_HI:`CMD_TYPE_LO];
  assign dst_stride       = stride_layout_reg[`STRIDE_DST_HI:`STRIDE_DST_LO];
  // source stride follows destination unless bit 24 is set
  assign src_stride = src_stride_own ? stride_layout_reg[`STRIDE_SRC_HI:0]
                                     : dst_stride;
  // two-operand code copies the low nibble upward
  assign raster_code_next = raster_code_two
                          ? {drawing_command_reg[3:0], drawing_command_reg[3:0]}
                          : drawing_command_reg[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // register writes; command reserved bits stay zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drawing_command_reg  <= `RST_DRAWING_COMMAND;
      foreground_color_reg <= `RST_COLOR;
      background_color_reg <= `RST_COLOR;
      stride_layout_reg    <= `RST_STRIDE_LAYOUT;
      color_compare_reg    <= `RST_COLOR;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `OFS_DRAWING_COMMAND:
          drawing_command_reg <= reg_wdata & `CMD_WRITE_MASK;
        `OFS_FOREGROUND_COLOR: foreground_color_reg <= reg_wdata;
        `OFS_BACKGROUND_COLOR: background_color_reg <= reg_wdata;
        `OFS_STRIDE_LAYOUT:    stride_layout_reg    <= reg_wdata;
        `OFS_COLOR_COMPARE:    color_compare_reg    <= reg_wdata;
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (reg_addr)
      `OFS_DRAWING_COMMAND:  rdata_next = drawing_command_reg;
      `OFS_FOREGROUND_COLOR: rdata_next = foreground_color_reg;
      `OFS_BACKGROUND_COLOR: rdata_next = background_color_reg;
      `OFS_STRIDE_LAYOUT:    rdata_next = stride_layout_reg;
      `OFS_COLOR_COMPARE:    rdata_next = color_compare_reg;
      `OFS_ENGINE_STATUS:    rdata_next = {8'h00, y_count_reg, 12'h000};
      default:               rdata_next = 32'h00000000;
    endcase
  end
  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_reg <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_reg <= rdata_next;
    else
      reg_rdata_reg <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command start pulse and type decode
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_start_reg <= 1'b0;
    else
      cmd_start_reg <= reg_wr && (reg_addr == `OFS_DRAWING_COMMAND)
                    && (reg_wdata[`CMD_TYPE_HI:`CMD_TYPE_LO] != CMD_NOP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pixel transparency and source color
  // equal skips at polarity 0, unequal skips at polarity 1
  assign color_skip = color_transp
                    && ((pix_in.rop_pixel == color_compare_reg) ^ color_transp_pol);
  // mono source or pattern only; background at polarity 0, foreground at 1
  assign mono_skip  = mono_transp && (mono_source || mono_pattern) && pix_in.mono_active
                    && (pix_in.mono_bit == mono_transp_pol);
  always_comb
  begin
    pix_out_next          = '0;
    pix_out_next.write_en = pix_in.valid && !color_skip && !mono_skip;
    if (mono_source)
    begin
      // mono source expands, or is forced solid
      if (solid_source)
        pix_out_next.src_pixel = foreground_color_reg;
      else if (pix_in.mono_bit)
        pix_out_next.src_pixel = foreground_color_reg;
      else
        pix_out_next.src_pixel = background_color_reg;
    end
    else
      pix_out_next.src_pixel = pix_in.fifo_data;
    // system-memory source consumes the fifo unless forced solid
    pix_out_next.fifo_pop = pix_in.valid
                          && drawing_command_reg[`BIT_SRC_SYSTEM]
                          && !(mono_source && solid_source);
  end
  // pixel decision register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pix_out_reg <= '0;
    else
      pix_out_reg <= pix_out_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // line stepping: up for positive y, down for negative
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      src_line_addr_reg <= 24'h000000;
      dst_line_addr_reg <= 24'h000000;
      y_count_reg       <= 12'h000;
    end
    else if (line_init.load)
    begin
      src_line_addr_reg <= line_init.src_addr;
      dst_line_addr_reg <= line_init.dst_addr;
      y_count_reg       <= line_init.y_start;
    end
    else if (line_done)
    begin
      // one stride and one line per step, sign from the y bit
      src_line_addr_reg <= y_negative ? src_line_addr_reg - {12'h000, src_stride}
                                      : src_line_addr_reg + {12'h000, src_stride};
      dst_line_addr_reg <= y_negative ? dst_line_addr_reg - {12'h000, dst_stride}
                                      : dst_line_addr_reg + {12'h000, dst_stride};
      y_count_reg       <= y_negative ? y_count_reg - 12'h001 : y_count_reg + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered field outputs
  logic [7:0] raster_code_reg;
  logic       src_from_system_reg;
  logic       packed_layout_reg;
  logic       cmd_is_blt_reg;
  logic       cmd_is_line_reg;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      raster_code_reg     <= 8'h00;
      src_from_system_reg <= 1'b0;
      packed_layout_reg   <= 1'b0;
      cmd_is_blt_reg      <= 1'b0;
      cmd_is_line_reg     <= 1'b0;
    end
    else
    begin
      raster_code_reg     <= raster_code_next;
      src_from_system_reg <= drawing_command_reg[`BIT_SRC_SYSTEM];
      packed_layout_reg   <= drawing_command_reg[`BIT_PACKED_LAYOUT];
      cmd_is_blt_reg      <= (cmd_type == CMD_BLT);
      cmd_is_line_reg     <= (cmd_type == CMD_LINE);
    end
  end
  assign reg_rdata       = reg_rdata_reg;
  assign pix_out         = pix_out_reg;
  assign src_line_addr   = src_line_addr_reg;
  assign dst_line_addr   = dst_line_addr_reg;
  assign y_count         = y_count_reg;
  assign raster_code     = raster_code_reg;
  assign src_from_system = src_from_system_reg;
  assign packed_layout   = packed_layout_reg;
  assign cmd_is_blt      = cmd_is_blt_reg;
  assign cmd_is_line     = cmd_is_line_reg;
  assign cmd_start       = cmd_start_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_y_step;
    !line_init.load && line_done |=>
      y_count_reg == ($past(y_negative) ? $past(y_count_reg) - 12'h001
                                        : $past(y_count_reg) + 12'h001);
  endproperty
  a_y_step: assert property (p_y_step) else $error("y step wrong");
  property p_src_system;
    ##1 src_from_system == $past(drawing_command_reg[`BIT_SRC_SYSTEM]);
  endproperty
  a_src_system: assert property (p_src_system) else $error("source select");
  property p_mono_expand;
    mono_source && !solid_source && pix_in.mono_bit |=>
      pix_out.src_pixel == $past(foreground_color_reg);
  endproperty
  a_mono_expand: assert property (p_mono_expand) else $error("mono expand");
  property p_color_skip;
    pix_in.valid && color_transp && !color_transp_pol
      && pix_in.rop_pixel == color_compare_reg |=> !pix_out.write_en;
  endproperty
  a_color_skip: assert property (p_color_skip) else $error("equal written");
  property p_color_pol;
    pix_in.valid && color_transp && color_transp_pol && !mono_skip
      && pix_in.rop_pixel == color_compare_reg |=> pix_out.write_en;
  endproperty
  a_color_pol: assert property (p_color_pol) else $error("polarity");
  property p_mono_skip;
    pix_in.valid && mono_transp && (mono_source || mono_pattern) && pix_in.mono_active
      && pix_in.mono_bit == mono_transp_pol |=> !pix_out.write_en;
  endproperty
  a_mono_skip: assert property (p_mono_skip) else $error("mono written");
  property p_mono_pol;
    pix_in.valid && !color_transp && mono_transp && pix_in.mono_active
      && pix_in.mono_bit != mono_transp_pol |=> pix_out.write_en;
  endproperty
  a_mono_pol: assert property (p_mono_pol) else $error("mono polarity");
  property p_packed;
    ##1 packed_layout == $past(drawing_command_reg[`BIT_PACKED_LAYOUT]);
  endproperty
  a_packed: assert property (p_packed) else $error("layout flag");
  property p_solid;
    mono_source && solid_source |=>
      pix_out.src_pixel == $past(foreground_color_reg) && !pix_out.fifo_pop;
  endproperty
  a_solid: assert property (p_solid) else $error("solid source");
  property p_stride_shared;
    line_done && !line_init.load && !src_stride_own |=>
      src_line_addr_reg - $past(src_line_addr_reg) == {12'h000, $past(dst_stride)}
      || $past(src_line_addr_reg) - src_line_addr_reg == {12'h000, $past(dst_stride)};
  endproperty
  a_stride_shared: assert property (p_stride_shared) else $error("stride");
  property p_code_two;
    raster_code_two |=> raster_code[7:4] == raster_code[3:0];
  endproperty
  a_code_two: assert property (p_code_two) else $error("raster code");
  property p_cmd_type;
    reg_wr && reg_addr == `OFS_DRAWING_COMMAND
      && reg_wdata[`CMD_TYPE_HI:`CMD_TYPE_LO] == CMD_BLT |=> cmd_start
      ##1 (cmd_is_blt || $past(reg_wr && reg_addr == `OFS_DRAWING_COMMAND));
  endproperty
  a_cmd_type: assert property (p_cmd_type) else $error("blit decode");
  property p_reserved;
    reg_rd && reg_addr == `OFS_DRAWING_COMMAND |=> reg_rdata[22:21] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits");
  c_blit_start:  cover property (cmd_start ##1 cmd_is_blt);
  c_color_skip:  cover property (pix_in.valid && color_skip);
  c_mono_skip:   cover property (pix_in.valid && mono_skip);
  c_line_down:   cover property (line_done && y_negative);
endmodule : blit_command_field_decode

// ===== blit_defines.svh
`ifndef BLIT_DEFINES_SVH
`define BLIT_DEFINES_SVH
// register byte offsets
`define OFS_DRAWING_COMMAND    12'h200
`define OFS_BACKGROUND_COLOR   12'h218
`define OFS_FOREGROUND_COLOR   12'h21C
`define OFS_STRIDE_LAYOUT      12'h224
`define OFS_COLOR_COMPARE      12'h228
`define OFS_ENGINE_STATUS      12'h2FC
// drawing command field positions
`define BIT_Y_NEGATIVE         12
`define BIT_SRC_SYSTEM         13
`define BIT_MONO_SOURCE        14
`define BIT_MONO_PATTERN       15
`define BIT_COLOR_TRANSP       16
`define BIT_COLOR_TRANSP_POL   17
`define BIT_MONO_TRANSP        18
`define BIT_MONO_TRANSP_POL    19
`define BIT_PACKED_LAYOUT      20
`define BIT_SOLID_SOURCE       23
`define BIT_SRC_STRIDE_OWN     24
`define BIT_RASTER_CODE_TWO    25
`define CMD_TYPE_HI            10
`define CMD_TYPE_LO            8
// writable bits of the command word: 22:21 are held at zero
`define CMD_WRITE_MASK         32'hFF9FFFFF
// reset values
`define RST_DRAWING_COMMAND    32'h00000000
`define RST_COLOR              32'h00000000
`define RST_STRIDE_LAYOUT      32'h00000000
// stride layout fields
`define STRIDE_SRC_HI          11
`define STRIDE_DST_HI          27
`define STRIDE_DST_LO          16
`endif

// ===== blit_pkg.sv
package blit_pkg;
  // command type codes
  typedef enum logic [2:0] {
    CMD_NOP  = 3'b000,
    CMD_BLT  = 3'b010,
    CMD_LINE = 3'b100
  } cmd_kind_type;
  // one pixel offered by the raster pipe
  typedef struct packed {
    logic        valid;       // pixel present this cycle
    logic [31:0] rop_pixel;   // raster-operation result
    logic        mono_bit;    // expanded mono bit, 1 = foreground
    logic        mono_active; // pixel came from mono source or pattern
    logic [31:0] fifo_data;   // source fifo word for this pixel
  } pix_in_type;
  // pixel decision handed to the memory writer
  typedef struct packed {
    logic        write_en;    // destination pixel is written
    logic [31:0] src_pixel;   // resolved source color
    logic        fifo_pop;    // one source fifo word consumed
  } pix_out_type;
  // line stepping load values
  typedef struct packed {
    logic        load;
    logic [23:0] src_addr;
    logic [23:0] dst_addr;
    logic [11:0] y_start;
  } line_init_type;
endpackage : blit_pkg

// ===== host_feed.sv
module host_feed
  import blit_pkg::*;
(
  input  wire logic ref_clk,
  output pix_in_type pix_in
);
  timeunit 1ns;
  timeprecision 1ps;

  pix_in_type pend_q[$];  // pixels queued by the host

  initial pix_in = '0;

  ////////////////////////////////////////////////////////////
  // one pixel an edge; when idle, drop valid and flip the data
  always @(posedge ref_clk)
  begin
    if (pend_q.size() > 0)
      pix_in <= pend_q.pop_front();
    else
      pix_in <= {1'h0, ~pix_in[65:0]};
  end

  // host hands over one source word with its pixel
  task automatic offer(input pix_in_type p);
    pend_q.push_back(p);
  endtask : offer
endmodule : host_feed

// ===== tb.sv
`include "blit_defines.svh"
module tb
  import blit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    pix_out_type e;    // expected decision
    logic        chk;  // source color is compared
  } exp_pix_type;

  logic          ref_clk;
  logic          arst_n;
  logic [11:0]   reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  pix_in_type    pix_in;
  pix_out_type   pix_out;
  line_init_type line_init;
  logic          line_done;
  logic [23:0]   src_line_addr;
  logic [23:0]   dst_line_addr;
  logic [11:0]   y_count;
  logic [7:0]    raster_code;
  logic          src_from_system;
  logic          packed_layout;
  logic          cmd_is_blt;
  logic          cmd_is_line;
  logic          cmd_start;
  logic [31:0]   rd_q[$];     // expected read data
  exp_pix_type   px_q[$];     // expected pixel decisions
  int            fail_count;
  int            samples_checked;
  logic [31:0]   seed, fg, bg, cmp, c, a, b, s;
  logic [23:0]   ea, eb;
  logic [11:0]   ss, ey;
  logic          rd_d, px_d;  // a result is due this cycle
  pix_in_type    p;

  blit_command_field_decode dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix_in(pix_in), .pix_out(pix_out), .line_init(line_init), .line_done(line_done),
    .src_line_addr(src_line_addr), .dst_line_addr(dst_line_addr), .y_count(y_count),
    .raster_code(raster_code), .src_from_system(src_from_system),
    .packed_layout(packed_layout), .cmd_is_blt(cmd_is_blt), .cmd_is_line(cmd_is_line),
    .cmd_start(cmd_start));

  host_feed host (.ref_clk(ref_clk), .pix_in(pix_in));

  ////////////////////////////////////////////////////////////
  // clock, 40 ns period
  always #20 ref_clk = ~ref_clk;

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  // closing report
  task automatic give_verdict();
    check(rd_q.size() + px_q.size(), 32'h0, "results left");
    $display("mismatches %0d, checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  // bus cycles, entered just after an edge
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic idle(input int n);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    repeat (n) step();
  endtask : idle

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    step();
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    rd_q.push_back(e);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    reg_wr <= 1'h0;
    step();
  endtask : rd

  // expected pixel decision
  function automatic exp_pix_type model(input logic [31:0] cw, input pix_in_type q);
    exp_pix_type x;
    logic        hide;
    hide = cw[16] && ((q.rop_pixel == cmp) ^ cw[17]);
    hide = hide || (cw[18] && (cw[14] || cw[15]) && q.mono_active
                    && (q.mono_bit == cw[19]));
    x.e.write_en = !hide;
    x.e.fifo_pop = cw[13] && !(cw[23] && cw[14]);
    x.e.src_pixel = cw[14] ? ((cw[23] || q.mono_bit) ? fg : bg) : q.fifo_data;
    x.chk = cw[14] || cw[13];
    return x;
  endfunction : model

  ////////////////////////////////////////////////////////////
  // watcher: results due one cycle after their request
  always @(posedge ref_clk)
  begin
    rd_d <= reg_rd;
    px_d <= pix_in.valid;
  end

  always @(negedge ref_clk)
  begin
    exp_pix_type ex;
    if (rd_d && rd_q.size() > 0)
      check(reg_rdata, rd_q.pop_front(), "read data");
    if (px_d && px_q.size() > 0)
    begin
      ex = px_q.pop_front();
      check({31'h0, pix_out.write_en}, {31'h0, ex.e.write_en}, "write enable");
      check({31'h0, pix_out.fifo_pop}, {31'h0, ex.e.fifo_pop}, "fifo pop");
      if (ex.chk)
        check(pix_out.src_pixel, ex.e.src_pixel, "source pixel");
    end
  end

  // hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    ref_clk = 1'h0;
    arst_n = 1'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    line_init = '0;
    line_done = 1'h0;
    seed = 32'h0000A3B2;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'h1;
    step();
    // reset value, unmapped place, colors
    rd(`OFS_DRAWING_COMMAND, `RST_DRAWING_COMMAND);
    rd(12'h3F0, 32'h0);
    fg = rnd();
    bg = rnd();
    cmp = rnd();
    wr(`OFS_FOREGROUND_COLOR, fg);
    wr(`OFS_BACKGROUND_COLOR, bg);
    wr(`OFS_COLOR_COMPARE, cmp);
    rd(`OFS_FOREGROUND_COLOR, fg);
    idle(1);
    // every type code, both raster code modes
    for (int i = 0; i < 16; i++)
    begin
      c = rnd();
      c[10:8] = i[2:0];
      c[25] = i[3];
      c[22:21] = 2'h3;
      c[15] = 1'h1;
      if (c[14])
        c[11] = 1'h0;
      wr(`OFS_DRAWING_COMMAND, c);
      check({31'h0, cmd_start}, {31'h0, c[10:8] != 3'h0}, "start pulse");
      idle(2);
      check({31'h0, cmd_is_blt}, {31'h0, c[10:8] == 3'h2}, "blit decode");
      check({31'h0, cmd_is_line}, {31'h0, c[10:8] == 3'h4}, "line decode");
      check({31'h0, src_from_system}, {31'h0, c[13]}, "source memory");
      check({31'h0, packed_layout}, {31'h0, c[20]}, "layout mode");
      check({24'h0, raster_code}, {24'h0, c[25] ? {c[3:0], c[3:0]} : c[7:0]}, "raster");
      rd(`OFS_DRAWING_COMMAND, c & `CMD_WRITE_MASK);
    end
    // line stepping, each direction and stride choice
    for (int i = 0; i < 4; i++)
    begin
      s = rnd() & 32'h0FFF0FFF;
      wr(`OFS_STRIDE_LAYOUT, s);
      c = 32'h00008200;
      c[12] = i[0];
      c[24] = i[1];
      wr(`OFS_DRAWING_COMMAND, c);
      idle(2);
      a = rnd();
      b = rnd();
      line_init <= {1'h1, a[23:0], b[23:0], b[31:20]};
      step();
      line_init.load <= 1'h0;
      line_done <= 1'h1;
      step();
      line_done <= 1'h0;
      step();
      ss = i[1] ? s[11:0] : s[27:16];
      ea = i[0] ? a[23:0] - {12'h0, ss} : a[23:0] + {12'h0, ss};
      eb = i[0] ? b[23:0] - {12'h0, s[27:16]} : b[23:0] + {12'h0, s[27:16]};
      ey = i[0] ? b[31:20] - 12'h1 : b[31:20] + 12'h1;
      check({20'h0, y_count}, {20'h0, ey}, "line count");
      check({8'h0, dst_line_addr}, {8'h0, eb}, "dest address");
      check({8'h0, src_line_addr}, {8'h0, ea}, "source address");
      rd(`OFS_STRIDE_LAYOUT, s);
      rd(`OFS_ENGINE_STATUS, {8'h0, ey, 12'h0});
    end
    // pixel decisions under random commands, four back to back each
    for (int i = 0; i < 64; i++)
    begin
      c = rnd();
      c[15] = 1'h1;
      if (c[14])
        c[11] = 1'h0;
      wr(`OFS_DRAWING_COMMAND, c);
      idle(2);
      for (int k = 0; k < 4; k++)
      begin
        a = rnd();
        b = rnd();
        p.valid = 1'h1;
        p.rop_pixel = a[0] ? cmp : b;
        p.mono_bit = a[1];
        p.mono_active = a[2];
        p.fifo_data = rnd();
        px_q.push_back(model(c, p));
        host.offer(p);
      end
      idle(6);
    end
    idle(4);
    give_verdict();
  end
endmodule : tb
